// File: tone_codec_defs.svh
// Timing counts, tone frequencies and reset values of the tone transceiver logic
`ifndef TONE_CODEC_DEFS_SVH
`define TONE_CODEC_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define REF_CLK_HZ 100000000
`define BURST_MS 51
`define BURST_CYCLES ((`REF_CLK_HZ / 1000) * `BURST_MS)
`define SEGMENTS 32
`define GUARD_PRESENT_US 40000
`define GUARD_ABSENT_US 40000
`define GUARD_PRESENT_CYCLES ((`REF_CLK_HZ / 1000000) * `GUARD_PRESENT_US)
`define GUARD_ABSENT_CYCLES ((`REF_CLK_HZ / 1000000) * `GUARD_ABSENT_US)

// ----------------------------------------
// Tone frequencies, low group then high group
// ----------------------------------------
`define FREQ_L1 697
`define FREQ_L2 770
`define FREQ_L3 852
`define FREQ_L4 941
`define FREQ_H1 1209
`define FREQ_H2 1336
`define FREQ_H3 1477
`define FREQ_H4 1633

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CODE_RESET 4'h0

`endif

// File: tone_codec_pkg.sv
// Types shared by the tone transceiver logic
package tone_codec_pkg;

	// Two tone group selections, row and column, each one-hot of four
	typedef struct packed {
		logic [3:0] row;
		logic [3:0] col;
	} tone_sel_t;

	// Host control bits
	typedef struct packed {
		logic tone_output_enable;
		logic progress_mode_select;
		logic irq_enable;
		logic burst_enable;
		logic single_tone;
		logic single_col;
	} ctrl_t;

	// Transmit burst phases
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_BURST,
		TX_PAUSE
	} tx_state_t;

	// Receive steering phases
	typedef enum logic [1:0] {
		RX_ABSENT,
		RX_QUAL_ON,
		RX_PRESENT,
		RX_QUAL_OFF
	} rx_state_t;

endpackage

// File: tone_divider.sv
// Programmable segment divider with 32-step sine address counter
`timescale 1ns/1ps
module tone_divider #(
	parameter int DIV_W = 13,
	parameter int ADDR_W = 5
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Control
	input wire logic run,
	input wire logic [DIV_W-1:0] seg_len,
	// Sine table address
	output logic [ADDR_W-1:0] sine_addr
);

	logic [DIV_W-1:0] div_count;
	wire seg_end = (div_count == seg_len);

	// --------------------------------------
	// Divider and address counter
	// --------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_count <= '0;
			sine_addr <= '0;
		end else if (clk_en) begin
			if (!run) begin
				div_count <= '0;
				sine_addr <= '0;
			end else if (seg_end) begin
				div_count <= '0;
				sine_addr <= sine_addr + 1'b1;
			end else begin
				div_count <= div_count + 1'b1;
			end
		end
	end

endmodule

// File: tone_codec.sv
// Tone transceiver receive register, steering, generator and burst timer
`timescale 1ns/1ps
`include "tone_codec_defs.svh"
module tone_codec #(
	parameter int CLK_HZ = `REF_CLK_HZ,
	parameter int BURST_CYCLES = `BURST_CYCLES,
	parameter int GUARD_PRESENT_CYCLES = `GUARD_PRESENT_CYCLES,
	parameter int GUARD_ABSENT_CYCLES = `GUARD_ABSENT_CYCLES,
	parameter int DIV_W = 13
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Control bits
	input wire tone_codec_pkg::ctrl_t ctrl,
	// Receiver front end
	input wire logic early_tone_detect,
	input wire logic [3:0] detected_code,
	// Transmit code write
	input wire logic tx_write,
	input wire logic [3:0] tx_code,
	// Status read strobe
	input wire logic status_read,
	// Receive and status outputs
	output logic [3:0] received_code_bits,
	output logic steering_guard_pin,
	output logic delayed_steering,
	output logic data_valid,
	output logic tx_ready,
	output logic interrupt_or_progress_pin_oe,
	// Transmit outputs
	output tone_codec_pkg::tone_sel_t tone_sel,
	output logic [4:0] row_addr,
	output logic [4:0] col_addr,
	output logic row_on,
	output logic col_on
);

	// --------------------------------------
	// Segment length for a tone frequency
	// --------------------------------------
	function automatic logic [DIV_W-1:0] seg_len_of(input int freq);
		int cycles;
		begin
			cycles = CLK_HZ / (freq * `SEGMENTS);
			seg_len_of = DIV_W'(cycles - 1);
		end
	endfunction

	// Digit code to two-of-eight selection, shared encoding
	function automatic tone_codec_pkg::tone_sel_t code_to_sel(
		input logic [3:0] code);
		tone_codec_pkg::tone_sel_t s;
		begin
			s = '0;
			case (code)
			4'h1: s = {4'h1, 4'h1};
			4'h2: s = {4'h1, 4'h2};
			4'h3: s = {4'h1, 4'h4};
			4'h4: s = {4'h2, 4'h1};
			4'h5: s = {4'h2, 4'h2};
			4'h6: s = {4'h2, 4'h4};
			4'h7: s = {4'h4, 4'h1};
			4'h8: s = {4'h4, 4'h2};
			4'h9: s = {4'h4, 4'h4};
			4'ha: s = {4'h8, 4'h2};
			4'hb: s = {4'h8, 4'h1};
			4'hc: s = {4'h8, 4'h4};
			4'hd: s = {4'h1, 4'h8};
			4'he: s = {4'h2, 4'h8};
			4'hf: s = {4'h4, 4'h8};
			default: s = {4'h8, 4'h8};
			endcase
			code_to_sel = s;
		end
	endfunction

	// One-hot group select to segment length
	function automatic logic [DIV_W-1:0] pick_len(input logic [3:0] oh,
		input logic high);
		begin
			case ({high, oh})
			5'h01: pick_len = seg_len_of(`FREQ_L1);
			5'h02: pick_len = seg_len_of(`FREQ_L2);
			5'h04: pick_len = seg_len_of(`FREQ_L3);
			5'h08: pick_len = seg_len_of(`FREQ_L4);
			5'h11: pick_len = seg_len_of(`FREQ_H1);
			5'h12: pick_len = seg_len_of(`FREQ_H2);
			5'h14: pick_len = seg_len_of(`FREQ_H3);
			5'h18: pick_len = seg_len_of(`FREQ_H4);
			default: pick_len = '0;
			endcase
		end
	endfunction

	// --------------------------------------
	// Receive steering
	// --------------------------------------
	tone_codec_pkg::rx_state_t rx_state;
	tone_codec_pkg::rx_state_t next_rx_state;
	logic [31:0] guard_count;
	logic dtmf_rx_allowed;
	logic guard_on_done;
	logic guard_off_done;
	logic latch_now;
	logic steer_release;

	// Reception off in call-progress mode
	assign dtmf_rx_allowed = !ctrl.progress_mode_select;
	assign guard_on_done = (guard_count >= 32'(GUARD_PRESENT_CYCLES - 1));
	assign guard_off_done = (guard_count >= 32'(GUARD_ABSENT_CYCLES - 1));
	assign latch_now = (rx_state == tone_codec_pkg::RX_QUAL_ON)
		&& dtmf_rx_allowed && early_tone_detect && guard_on_done;
	assign steer_release = (rx_state == tone_codec_pkg::RX_QUAL_OFF)
		&& !early_tone_detect && guard_off_done;

	// Next steering state
	always_comb begin
		next_rx_state = rx_state;
		case (rx_state)
		tone_codec_pkg::RX_ABSENT: begin
			if (early_tone_detect && dtmf_rx_allowed)
				next_rx_state = tone_codec_pkg::RX_QUAL_ON;
		end
		tone_codec_pkg::RX_QUAL_ON: begin
			if (!early_tone_detect || !dtmf_rx_allowed)
				next_rx_state = tone_codec_pkg::RX_ABSENT;
			else if (guard_on_done)
				next_rx_state = tone_codec_pkg::RX_PRESENT;
		end
		tone_codec_pkg::RX_PRESENT: begin
			if (!early_tone_detect)
				next_rx_state = tone_codec_pkg::RX_QUAL_OFF;
		end
		tone_codec_pkg::RX_QUAL_OFF: begin
			if (early_tone_detect)
				next_rx_state = tone_codec_pkg::RX_PRESENT;
			else if (guard_off_done)
				next_rx_state = tone_codec_pkg::RX_ABSENT;
		end
		default: next_rx_state = tone_codec_pkg::RX_ABSENT;
		endcase
	end

	// Guard counter restarts on every state change
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state <= tone_codec_pkg::RX_ABSENT;
			guard_count <= 32'h0;
		end else if (clk_en) begin
			rx_state <= next_rx_state;
			if (next_rx_state != rx_state)
				guard_count <= 32'h0;
			else
				guard_count <= guard_count + 32'h1;
		end
	end

	// Code latch, steering and guard outputs
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			received_code_bits <= `CODE_RESET;
			delayed_steering <= 1'b0;
			steering_guard_pin <= 1'b0;
		end else if (clk_en) begin
			if (latch_now)
				received_code_bits <= detected_code;
			if (latch_now)
				delayed_steering <= 1'b1;
			else if (steer_release)
				delayed_steering <= 1'b0;
			steering_guard_pin <= (next_rx_state == tone_codec_pkg::RX_PRESENT)
				|| (next_rx_state == tone_codec_pkg::RX_QUAL_OFF);
		end
	end

	// --------------------------------------
	// Burst timer
	// --------------------------------------
	tone_codec_pkg::tx_state_t tx_state;
	logic [31:0] burst_count;
	logic [31:0] phase_len;
	logic phase_done;

	// Call-progress mode doubles the phase
	assign phase_len = ctrl.progress_mode_select
		? 32'(2 * BURST_CYCLES - 1) : 32'(BURST_CYCLES - 1);
	assign phase_done = (burst_count >= phase_len);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_state <= tone_codec_pkg::TX_IDLE;
			burst_count <= 32'h0;
		end else if (clk_en) begin
			case (tx_state)
			tone_codec_pkg::TX_IDLE: begin
				burst_count <= 32'h0;
				if (tx_write && ctrl.burst_enable && ctrl.tone_output_enable)
					tx_state <= tone_codec_pkg::TX_BURST;
			end
			tone_codec_pkg::TX_BURST: begin
				burst_count <= phase_done ? 32'h0 : burst_count + 32'h1;
				if (phase_done)
					tx_state <= tone_codec_pkg::TX_PAUSE;
			end
			tone_codec_pkg::TX_PAUSE: begin
				burst_count <= phase_done ? 32'h0 : burst_count + 32'h1;
				if (phase_done)
					tx_state <= tone_codec_pkg::TX_IDLE;
			end
			default: tx_state <= tone_codec_pkg::TX_IDLE;
			endcase
		end
	end

	// --------------------------------------
	// Status flags and interrupt
	// --------------------------------------
	logic burst_finish;
	logic finish_seen;
	logic next_irq;
	assign burst_finish = (tx_state == tone_codec_pkg::TX_PAUSE)
		&& phase_done;
	assign next_irq = ctrl.irq_enable && !ctrl.progress_mode_select
		&& (data_valid || (tx_ready && ctrl.burst_enable));

	// Set wins over the read clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_valid <= 1'b0;
			tx_ready <= 1'b0;
			finish_seen <= 1'b0;
			interrupt_or_progress_pin_oe <= 1'b0;
		end else if (clk_en) begin
			if (latch_now)
				data_valid <= 1'b1;
			else if (status_read)
				data_valid <= 1'b0;
			// Ready one cycle late, so the registered gap is whole
			finish_seen <= burst_finish;
			if (finish_seen)
				tx_ready <= 1'b1;
			else if (tx_write || status_read)
				tx_ready <= 1'b0;
			interrupt_or_progress_pin_oe <= next_irq
				&& !(status_read && !latch_now && !finish_seen);
		end
	end

	// --------------------------------------
	// Tone generator
	// --------------------------------------
	tone_codec_pkg::tone_sel_t next_sel;
	logic tone_run;
	logic next_row_on;
	logic next_col_on;
	logic [4:0] row_a;
	logic [4:0] col_a;

	assign next_sel = code_to_sel(tx_code);
	// Enable bit gates tones; burst gating when burst mode on
	assign tone_run = ctrl.tone_output_enable && (!ctrl.burst_enable
		|| tx_state == tone_codec_pkg::TX_BURST);
	assign next_row_on = tone_run && !(ctrl.single_tone && ctrl.single_col);
	assign next_col_on = tone_run && !(ctrl.single_tone && !ctrl.single_col);

	// Transmit code latch and output registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tone_sel <= code_to_sel(`CODE_RESET);
			row_on <= 1'b0;
			col_on <= 1'b0;
			row_addr <= 5'h00;
			col_addr <= 5'h00;
		end else if (clk_en) begin
			if (tx_write)
				tone_sel <= next_sel;
			row_on <= next_row_on;
			col_on <= next_col_on;
			row_addr <= row_a;
			col_addr <= col_a;
		end
	end

	// Identical row and column dividers
	tone_divider #(.DIV_W(DIV_W), .ADDR_W(5)) u_row_div (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.run(next_row_on),
		.seg_len(pick_len(tone_sel.row, 1'b0)),
		.sine_addr(row_a)
	);

	tone_divider #(.DIV_W(DIV_W), .ADDR_W(5)) u_col_div (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.run(next_col_on),
		.seg_len(pick_len(tone_sel.col, 1'b1)),
		.sine_addr(col_a)
	);

endmodule

// File: tone_codec_monitor.sv
// Port timing checker of the tone transceiver logic
`timescale 1ns/1ps
module tone_codec_monitor #(
	parameter int BURST_CYCLES = 100,
	parameter int GUARD_PRESENT_CYCLES = 20,
	parameter int GUARD_ABSENT_CYCLES = 20
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Inputs
	input wire tone_codec_pkg::ctrl_t ctrl,
	input wire logic early_tone_detect,
	input wire logic tx_write,
	input wire logic status_read,
	// Outputs
	input wire logic [3:0] received_code_bits,
	input wire logic delayed_steering,
	input wire logic data_valid,
	input wire logic tx_ready,
	input wire logic interrupt_or_progress_pin_oe,
	input wire logic row_on,
	input wire logic col_on
);
	int hi_cnt;
	int lo_cnt;
	int on_cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Run lengths of detect high, detect low, row tone on
	// Counts include the edge that first saw the level
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_cnt <= 0;
			lo_cnt <= 0;
			on_cnt <= 0;
		end else begin
			hi_cnt <= early_tone_detect ? hi_cnt + 1 : 0;
			lo_cnt <= early_tone_detect ? 0 : lo_cnt + 1;
			on_cnt <= row_on ? on_cnt + 1 : 0;
		end
	end
	// ----
	// Receive side
	// ----
	AST_PRESENT_GUARD: assert property (
		$rose(delayed_steering) |-> hi_cnt == GUARD_PRESENT_CYCLES + 1)
		else $error("steering rose off guard count");
	AST_ABSENT_GUARD: assert property (
		$fell(delayed_steering) |-> lo_cnt == GUARD_ABSENT_CYCLES + 1)
		else $error("steering fell off guard count");
	AST_CODE_ON_EDGE: assert property (
		!$stable(received_code_bits) |-> $rose(delayed_steering))
		else $error("code changed without steering edge");
	AST_VALID_SET: assert property (
		$rose(delayed_steering) |-> data_valid)
		else $error("valid flag not set on latch");
	AST_READ_CLEAR: assert property (
		status_read && !early_tone_detect |=> !data_valid)
		else $error("valid flag kept after read");
	AST_IRQ_ON: assert property (
		data_valid && !status_read && ctrl.irq_enable &&
		!ctrl.progress_mode_select |=> interrupt_or_progress_pin_oe)
		else $error("interrupt missing on new data");
	AST_IRQ_OFF: assert property (
		!ctrl.irq_enable |=> !interrupt_or_progress_pin_oe)
		else $error("interrupt while disabled");
	AST_NO_RX_PROGRESS: assert property (
		ctrl.progress_mode_select |=> !$rose(delayed_steering))
		else $error("digit taken in progress mode");
	// ----
	// Transmit side
	// ----
	AST_TONE_GATE: assert property (
		!ctrl.tone_output_enable |=> !row_on && !col_on)
		else $error("tone on while output disabled");
	AST_BURST_LEN: assert property (
		$fell(row_on) && ctrl.burst_enable |-> on_cnt ==
		(ctrl.progress_mode_select ? 2 * BURST_CYCLES : BURST_CYCLES))
		else $error("burst length wrong");
	AST_WRITE_CLEARS: assert property (
		tx_write |=> !tx_ready)
		else $error("ready kept after write");
endmodule
bind tone_codec tone_codec_monitor #(
	.BURST_CYCLES(BURST_CYCLES),
	.GUARD_PRESENT_CYCLES(GUARD_PRESENT_CYCLES),
	.GUARD_ABSENT_CYCLES(GUARD_ABSENT_CYCLES)
) mon (.ref_clk, .rst_b, .ctrl, .early_tone_detect, .tx_write,
	.status_read, .received_code_bits, .delayed_steering, .data_valid,
	.tx_ready, .interrupt_or_progress_pin_oe, .row_on, .col_on);

// File: host_model.sv
// Host side model: transmit code writes and status reads
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic ref_clk,
	// Host strobes
	output logic tx_write,
	output logic [3:0] tx_code,
	output logic status_read
);
	// Idle strobes at time zero
	initial begin
		tx_write = 1'b0;
		tx_code = 4'h0;
		status_read = 1'b0;
	end
	// One-cycle write of a receiver-style digit code
	task automatic write_code(input logic [3:0] c);
		@(negedge ref_clk);
		tx_code = c;
		tx_write = 1'b1;
		@(negedge ref_clk);
		tx_write = 1'b0;
		tx_code = ~c;
	endtask
	// One-cycle status read
	task automatic read_status();
		@(negedge ref_clk);
		status_read = 1'b1;
		@(negedge ref_clk);
		status_read = 1'b0;
	endtask
endmodule

// File: tb_dual_tone_burst_tx_rx_register_logic.sv
// Self-checking bench of the tone transceiver logic
`timescale 1ns/1ps
`include "tone_codec_defs.svh"
module tb_dual_tone_burst_tx_rx_register_logic;
	localparam int B = 100;
	localparam int G = 20;
	localparam int HZ = 1000000;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	tone_codec_pkg::ctrl_t ctrl = '0;
	logic early_tone_detect = 1'b0;
	logic [3:0] detected_code = 4'h0;
	logic tx_write, status_read, steering_guard_pin, delayed_steering;
	logic data_valid, tx_ready, interrupt_or_progress_pin_oe;
	logic row_on, col_on;
	logic [3:0] tx_code, received_code_bits;
	logic [4:0] row_addr, col_addr;
	tone_codec_pkg::tone_sel_t tone_sel;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int on_n, off_n;
	// Row and column index per digit code, two bits each
	logic [31:0] row_map = 32'h93fa9503;
	logic [31:0] col_map = 32'hfe192493;

	tone_codec #(.CLK_HZ(HZ), .BURST_CYCLES(B),
		.GUARD_PRESENT_CYCLES(G), .GUARD_ABSENT_CYCLES(G)) uut (
		.ref_clk, .rst_b, .clk_en, .ctrl, .early_tone_detect,
		.detected_code, .tx_write, .tx_code, .status_read,
		.received_code_bits, .steering_guard_pin, .delayed_steering,
		.data_valid, .tx_ready, .interrupt_or_progress_pin_oe,
		.tone_sel, .row_addr, .col_addr, .row_on, .col_on);
	host_model host (.ref_clk, .tx_write, .tx_code, .status_read);

	// Free-running reference clock
	always #5 ref_clk = ~ref_clk;
	// Cycle ceiling against a hung run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Detected tone pair held for hi cycles, then released
	task automatic tone(input logic [3:0] c, input int hi);
		@(negedge ref_clk);
		detected_code = c;
		early_tone_detect = 1'b1;
		idle(hi);
		early_tone_detect = 1'b0;
		detected_code = ~c;
	endtask
	// Burst write, counting tone-on and pause cycles until ready
	task automatic burst(input logic [3:0] c);
		host.write_code(c);
		on_n = 0;
		off_n = 0;
		while (!tx_ready) begin
			if (row_on)
				on_n++;
			else if (on_n > 0)
				off_n++;
			@(negedge ref_clk);
		end
	endtask
	// Sine address steps once per segment of seg cycles
	task automatic sweep(input logic col, input int seg);
		logic [4:0] p;
		logic [4:0] a;
		int n;
		for (int k = 0; k < 33; k++) begin
			p = col ? col_addr : row_addr;
			a = p;
			n = 0;
			while (a === p) begin
				@(negedge ref_clk);
				n++;
				a = col ? col_addr : row_addr;
			end
			chk(a, 5'(p + 5'h1));
			if (k > 0)
				chk(n[7:0], 8'(seg));
		end
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// Test sequence
	// ----
	initial begin
		idle(5);
		rst_b = 1'b1;
		chk(tone_sel, 8'h88);
		chk({received_code_bits, delayed_steering, data_valid, tx_ready,
			interrupt_or_progress_pin_oe}, 8'h00);
		// Every digit code through the transmit latch
		for (int c = 0; c < 16; c++) begin
			host.write_code(c[3:0]);
			idle(1);
			chk(tone_sel, {4'h1 << row_map[2*c+:2],
				4'h1 << col_map[2*c+:2]});
		end
		// Receive: short tone, valid tone, dropout, absence, read
		ctrl = 6'h08;
		tone(4'h5, G - 5);
		idle(G + 5);
		chk({received_code_bits, delayed_steering, data_valid}, 8'h00);
		tone(4'h5, G + 10);
		chk({received_code_bits, steering_guard_pin, delayed_steering,
			data_valid, interrupt_or_progress_pin_oe}, 8'h5f);
		idle(5);
		tone(4'h9, 10);
		chk({received_code_bits, steering_guard_pin,
			delayed_steering}, 6'h17);
		idle(G + 5);
		chk({received_code_bits, steering_guard_pin,
			delayed_steering}, 6'h14);
		host.read_status();
		idle(1);
		chk({data_valid, interrupt_or_progress_pin_oe}, 8'h0);
		tone(4'hc, G + 2);
		idle(G + 5);
		host.read_status();
		chk(received_code_bits, 4'hc);
		// No reception in progress mode
		ctrl = 6'h18;
		tone(4'h3, G + 10);
		idle(G + 5);
		chk({received_code_bits, data_valid}, {4'hc, 1'b0});
		// Burst and pause, plain then doubled
		ctrl = 6'h2c;
		burst(4'h1);
		idle(1);
		chk(on_n[7:0], 8'(B));
		chk(off_n[7:0], 8'(B));
		chk({tx_ready, interrupt_or_progress_pin_oe}, 8'h3);
		ctrl = 6'h3c;
		burst(4'h2);
		chk(on_n[7:0], 8'(2 * B));
		chk(off_n[7:0], 8'(2 * B));
		ctrl = 6'h00;
		host.write_code(4'h3);
		chk({tx_ready, row_on, col_on}, 8'h0);
		// Single row tone, sine address steps through one period
		ctrl = 6'h22;
		idle(3);
		chk({row_on, col_on}, 8'h2);
		sweep(1'b0, HZ / (`FREQ_L1 * `SEGMENTS));
		// Low clock enable freezes the tone state
		clk_en = 1'b0;
		ctrl = 6'h23;
		idle(3);
		chk({row_on, col_on}, 8'h2);
		clk_en = 1'b1;
		idle(3);
		chk({row_on, col_on}, 8'h1);
		sweep(1'b1, HZ / (`FREQ_H3 * `SEGMENTS));
		// Host-timed tone off
		ctrl = 6'h00;
		idle(2);
		chk({row_on, col_on}, 8'h0);
		conclude();
	end
endmodule
